// ===== sdram_host_pkg.sv
// Constants shared by the SDRAM bank-closing, refresh and power controller.
// Assumes a 20 MHz system clock and a four-bank single-data-rate SDRAM.
package sdram_host_pkg;

    // ------------------------------------------------------------------
    // Clock and device timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ     = 20;
    localparam int T_RP_NS     = 20;     // Row precharge time
    localparam int T_RFC_NS    = 66;     // Refresh cycle time
    localparam int T_RAS_NS    = 42;     // Least time held in self refresh
    localparam int T_XSR_NS    = 70;     // Self refresh exit time
    localparam int T_WR_NS     = 14;     // Write recovery
    localparam int T_REFI_NS   = 15600;  // Refresh period divided by row count
    localparam int XSR_MIN_CYC = 2;
    // Least times round up, the refresh interval rounds down
    localparam int T_RP_CYC    = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int T_RFC_CYC   = (T_RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int T_RAS_CYC   = (T_RAS_NS * CLK_MHZ + 999) / 1000;
    localparam int T_WR_CYC    = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int T_XSR_RAW   = (T_XSR_NS * CLK_MHZ + 999) / 1000;
    localparam int T_XSR_CYC   = (T_XSR_RAW < XSR_MIN_CYC) ? XSR_MIN_CYC : T_XSR_RAW;
    localparam int T_REFI_CYC  = (T_REFI_NS * CLK_MHZ) / 1000;
    localparam int DQM_LEAD    = 2;      // Mask lead before a write cuts a read
    localparam int FULL_PAGE   = 256;    // Columns in a page

    // ------------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_REFCNT = 8'h0c;
    localparam int CTRL_REF_EN = 0;
    localparam int CTRL_BL_LSB = 1;      // Burst length code, 3 bits; 7 is full page
    localparam int CTRL_WBM    = 4;      // write_burst_mode_bit copy
    localparam int CMD_OP_LSB  = 0;      // 4 bits
    localparam int CMD_BA_LSB  = 4;      // 2 bits
    localparam int CMD_A10     = 6;      // Auto precharge or all banks
    localparam int CMD_AD_LSB  = 8;      // 12 bits row or column
    localparam logic       CTRL_REF_EN_RST = 1'b1;
    localparam logic [2:0] CTRL_BL_RST     = 3'h2;
    localparam logic [2:0] BL_FULL         = 3'h7;

    // ------------------------------------------------------------------
    // Software operations and pin commands {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_ACT = 4'h1, OP_READ = 4'h2, OP_WRITE = 4'h3,
        OP_PRE = 4'h4, OP_REF = 4'h5, OP_SELF_IN = 4'h6, OP_SELF_OUT = 4'h7,
        OP_PD_IN = 4'h8, OP_PD_OUT = 4'h9, OP_SUSPEND = 4'ha, OP_RESUME = 4'hb
    } op_e;

    localparam logic [3:0] PIN_NOP   = 4'h7;
    localparam logic [3:0] PIN_ACT   = 4'h3;
    localparam logic [3:0] PIN_READ  = 4'h5;
    localparam logic [3:0] PIN_WRITE = 4'h4;
    localparam logic [3:0] PIN_PRE   = 4'h2;
    localparam logic [3:0] PIN_REF   = 4'h1;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0, ST_DQM  = 4'h1, ST_RFC  = 4'h2, ST_SELF = 4'h3,
        ST_XSR    = 4'h4, ST_PDWN = 4'h5, ST_PREW = 4'h6
    } state_e;

endpackage

// ===== sdram_host.sv
// Host-side controller that closes banks, refreshes and powers down an SDRAM.
// Assumes an APB master on the same clock and SDRAM pins sampled on pclk rises.
// Data pins are handled elsewhere; this block drives command, address and mask.

// Summary of operation
// - Wait precharge time, activate before access
// - Bank busy until auto precharge time elapses
// - Write cuts read; mask two clocks before; here the mask rises three clocks before the write
// - Refresh only with all banks precharged
// - Only NOPs during refresh cycle time
// - Distributed refresh at period over rows
// - Self refresh: refresh with clock enable low
// - Stay in self refresh at least tRAS
// - Exit: raise clock enable, NOPs for tXSR
// - Resume distributed refresh after self refresh
// - Leave power-down before refresh falls due; here it leaves once ref_pend is set
// - Power-down exit: NOP with enable high
module sdram_host (
    // Clock, reset, freeze
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // SDRAM command pins
    output logic             sd_cke,
    output logic             sd_cs_n,
    output logic             sd_ras_n,
    output logic             sd_cas_n,
    output logic             sd_we_n,
    output logic      [1:0]  sd_ba,
    output logic      [11:0] sd_addr,
    output logic             sd_dqm
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        sdram_host_pkg::state_e state;
        logic [7:0]             cnt;
        logic [15:0]            refi;
        logic                   ref_pend;
        logic                   ref_en;
        logic [2:0]             bl;
        logic                   wbm;
        logic                   pend;
        logic [3:0]             pop;
        logic [1:0]             pbank;
        logic                   pa10;
        logic [11:0]            paddr;
        logic [3:0]             bank_open;
        logic [3:0][7:0]        bank_wait;
        logic [8:0]             burst_rem;
        logic [1:0]             burst_bank;
        logic                   burst_wr;
        logic                   burst_ap;
        logic                   suspend;
        logic [15:0]            refcnt;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   cke;
        logic [3:0]             cmd;
        logic [1:0]             ba;
        logic [11:0]            a;
        logic                   dqm;
    } host_s;

    host_s cur;
    host_s next_cur;

    // Burst length in cycles; single-location writes take one column
    function automatic logic [8:0] burst_cycles(input logic [2:0] bl, input logic wr,
                                                input logic wbm);
        if (wr && wbm) begin
            burst_cycles = 9'h001;
        end else if (bl == sdram_host_pkg::BL_FULL) begin
            burst_cycles = 9'(sdram_host_pkg::FULL_PAGE);
        end else begin
            burst_cycles = 9'h001 << bl;
        end
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic       apb_acc;
    logic       all_idle;
    logic       do_ref;
    logic [8:0] len;
    logic [1:0] b;

    always_comb begin
        next_cur = cur;
        apb_acc  = psel && penable && cur.pready;
        all_idle = (cur.bank_open == 4'h0) && (cur.bank_wait == '0);
        do_ref   = 1'b0;
        len      = 9'h000;
        b        = cur.pbank;

        // Pins default to NOP each cycle; mask follows the DQM lead state
        next_cur.cmd = sdram_host_pkg::PIN_NOP;
        next_cur.dqm = 1'b0;

        // APB answers one cycle into the access phase
        next_cur.pready  = psel && penable && !cur.pready;
        next_cur.pslverr = 1'b0;
        if (psel && penable && !cur.pready) begin
            next_cur.prdata = 32'h0000_0000;
            case (paddr)
                sdram_host_pkg::REG_CTRL: next_cur.prdata = {27'h0, cur.wbm, cur.bl, cur.ref_en};
                sdram_host_pkg::REG_CMD: next_cur.prdata = 32'h0000_0000;
                sdram_host_pkg::REG_STATUS: next_cur.prdata = {19'h0, cur.suspend,
                    (cur.burst_rem != 9'h000), cur.cke, cur.state, cur.bank_open,
                    cur.ref_pend, cur.pend};
                sdram_host_pkg::REG_REFCNT: next_cur.prdata = {16'h0, cur.refcnt};
                default: next_cur.pslverr = 1'b1;
            endcase
        end
        if (apb_acc && pwrite) begin
            if (paddr == sdram_host_pkg::REG_CTRL) begin
                next_cur.ref_en = pwdata[sdram_host_pkg::CTRL_REF_EN];
                next_cur.bl     = pwdata[sdram_host_pkg::CTRL_BL_LSB +: 3];
                next_cur.wbm    = pwdata[sdram_host_pkg::CTRL_WBM];
            end else if (paddr == sdram_host_pkg::REG_CMD && !cur.pend) begin
                // A command is held until it can legally issue or is dropped
                next_cur.pend  = 1'b1;
                next_cur.pop   = pwdata[sdram_host_pkg::CMD_OP_LSB +: 4];
                next_cur.pbank = pwdata[sdram_host_pkg::CMD_BA_LSB +: 2];
                next_cur.pa10  = pwdata[sdram_host_pkg::CMD_A10];
                next_cur.paddr = pwdata[sdram_host_pkg::CMD_AD_LSB +: 12];
            end
        end

        // Per-bank precharge timers count down
        for (int i = 0; i < 4; i++) begin
            if (cur.bank_wait[i] != 8'h00) begin
                next_cur.bank_wait[i] = cur.bank_wait[i] - 8'h01;
            end
        end

        // Burst counter holds while the clock is suspended
        if (cur.burst_rem != 9'h000 && cur.cke) begin
            next_cur.burst_rem = cur.burst_rem - 9'h001;
            if (cur.burst_rem == 9'h001) begin
                next_cur.burst_ap = 1'b0;
            end
        end

        // Refresh interval timer; the due flag wins over its own clear
        if (cur.refi != 16'h0000) begin
            next_cur.refi = cur.refi - 16'h0001;
        end else if (cur.ref_en) begin
            next_cur.refi     = 16'(sdram_host_pkg::T_REFI_CYC - 1);
            next_cur.ref_pend = 1'b1;
        end
        if (cur.cnt != 8'h00) begin
            next_cur.cnt = cur.cnt - 8'h01;
        end

        case (cur.state)
            sdram_host_pkg::ST_IDLE: begin
                do_ref = (cur.ref_pend && cur.ref_en) ||
                         (cur.pend && (cur.pop == sdram_host_pkg::OP_REF ||
                                       cur.pop == sdram_host_pkg::OP_SELF_IN));
                if (cur.suspend) begin
                    // Clock enable stays low until software resumes
                    if (cur.pend && cur.pop == sdram_host_pkg::OP_RESUME) begin
                        next_cur.cke     = 1'b1;
                        next_cur.suspend = 1'b0;
                        next_cur.pend    = 1'b0;
                    end
                end else if (do_ref && cur.burst_rem == 9'h000) begin
                    if (cur.bank_open != 4'h0) begin
                        // Close everything before refreshing
                        next_cur.cmd       = sdram_host_pkg::PIN_PRE;
                        next_cur.a         = 12'h400;
                        next_cur.bank_open = 4'h0;
                        next_cur.bank_wait = {4{8'(sdram_host_pkg::T_RP_CYC)}};
                    end else if (all_idle) begin
                        next_cur.cmd    = sdram_host_pkg::PIN_REF;
                        next_cur.refcnt = cur.refcnt + 16'h0001;
                        if (cur.pend && cur.pop == sdram_host_pkg::OP_SELF_IN) begin
                            next_cur.cke   = 1'b0;
                            next_cur.state = sdram_host_pkg::ST_SELF;
                            next_cur.cnt   = 8'(sdram_host_pkg::T_RAS_CYC);
                        end else begin
                            next_cur.state = sdram_host_pkg::ST_RFC;
                            next_cur.cnt   = 8'(sdram_host_pkg::T_RFC_CYC);
                        end
                        if (cur.pend && cur.pop != sdram_host_pkg::OP_SELF_IN) begin
                            next_cur.pend = 1'b0;
                        end
                        next_cur.ref_pend = (cur.refi == 16'h0000) && cur.ref_en; // Set wins
                    end
                end else if (cur.pend) begin
                    case (cur.pop)
                        sdram_host_pkg::OP_ACT: begin
                            if (!cur.bank_open[b] && cur.bank_wait[b] == 8'h00) begin
                                next_cur.cmd          = sdram_host_pkg::PIN_ACT;
                                next_cur.ba           = b;
                                next_cur.a            = cur.paddr;
                                next_cur.bank_open[b] = 1'b1;
                                next_cur.pend         = 1'b0;
                            end
                        end
                        sdram_host_pkg::OP_READ, sdram_host_pkg::OP_WRITE: begin
                            if (!cur.bank_open[b] || cur.bank_wait[b] != 8'h00) begin
                                // Idle bank: drop the access, software must activate
                                next_cur.pend = cur.bank_open[b];
                            end else if (cur.pop == sdram_host_pkg::OP_WRITE &&
                                         cur.burst_rem != 9'h000 && !cur.burst_wr) begin
                                next_cur.state = sdram_host_pkg::ST_DQM;
                                next_cur.cnt   = 8'(sdram_host_pkg::DQM_LEAD - 1);
                                next_cur.dqm   = 1'b1;
                            end else begin
                                next_cur.state = sdram_host_pkg::ST_PREW;
                            end
                        end
                        sdram_host_pkg::OP_PRE: begin
                            next_cur.cmd = sdram_host_pkg::PIN_PRE;
                            next_cur.ba  = b;
                            next_cur.a   = {1'b0, cur.pa10, 10'h000};
                            for (int i = 0; i < 4; i++) begin
                                if (cur.pa10 || b == 2'(i)) begin
                                    next_cur.bank_open[i] = 1'b0;
                                    next_cur.bank_wait[i] = 8'(sdram_host_pkg::T_RP_CYC);
                                end
                            end
                            next_cur.pend = 1'b0;
                        end
                        sdram_host_pkg::OP_PD_IN: begin
                            if (cur.burst_rem == 9'h000) begin
                                next_cur.cke   = 1'b0;
                                next_cur.state = sdram_host_pkg::ST_PDWN;
                                next_cur.pend  = 1'b0;
                            end
                        end
                        sdram_host_pkg::OP_SUSPEND: begin
                            next_cur.pend = cur.burst_rem == 9'h000;
                            if (cur.burst_rem != 9'h000) begin
                                next_cur.cke     = 1'b0;
                                next_cur.suspend = 1'b1;
                            end
                        end
                        default: next_cur.pend = 1'b0;
                    endcase
                end
            end
            sdram_host_pkg::ST_DQM: begin
                // Mask read data ahead of the write to avoid contention
                next_cur.dqm = 1'b1;
                if (cur.cnt == 8'h00) begin
                    next_cur.state = sdram_host_pkg::ST_PREW;
                end
            end
            sdram_host_pkg::ST_PREW: begin
                // Issue the held read or write on the bus
                len = burst_cycles(cur.bl, cur.pop == sdram_host_pkg::OP_WRITE, cur.wbm);
                if (cur.burst_rem != 9'h000 && cur.burst_ap && cur.burst_bank != b) begin
                    // Cut burst starts its precharge now, after write recovery if a write
                    next_cur.bank_wait[cur.burst_bank] = cur.burst_wr ?
                        8'(sdram_host_pkg::T_WR_CYC + sdram_host_pkg::T_RP_CYC) :
                        8'(sdram_host_pkg::T_RP_CYC);
                end
                next_cur.cmd        = (cur.pop == sdram_host_pkg::OP_WRITE) ?
                                      sdram_host_pkg::PIN_WRITE : sdram_host_pkg::PIN_READ;
                next_cur.ba         = b;
                next_cur.a          = {1'b0, cur.pa10, 2'b00, cur.paddr[7:0]};
                next_cur.burst_rem  = len;
                next_cur.burst_bank = b;
                next_cur.burst_wr   = cur.pop == sdram_host_pkg::OP_WRITE;
                next_cur.burst_ap   = cur.pa10 && len != 9'(sdram_host_pkg::FULL_PAGE);
                if (cur.pa10 && len != 9'(sdram_host_pkg::FULL_PAGE)) begin
                    next_cur.bank_open[b] = 1'b0;
                    next_cur.bank_wait[b] = 8'(len) + 8'(sdram_host_pkg::T_RP_CYC) +
                        ((cur.pop == sdram_host_pkg::OP_WRITE) ?
                         8'(sdram_host_pkg::T_WR_CYC) : 8'h00);
                end
                next_cur.pend  = 1'b0;
                next_cur.state = sdram_host_pkg::ST_IDLE;
            end
            sdram_host_pkg::ST_RFC: begin
                // Only NOPs until the refresh cycle time has run out
                if (cur.cnt == 8'h00) begin
                    next_cur.state = sdram_host_pkg::ST_IDLE;
                end
            end
            sdram_host_pkg::ST_SELF: begin
                // Held at least tRAS; the exit order waits for that
                if (cur.cnt == 8'h00 && cur.pend && cur.pop == sdram_host_pkg::OP_SELF_OUT) begin
                    next_cur.cke   = 1'b1;
                    next_cur.state = sdram_host_pkg::ST_XSR;
                    next_cur.cnt   = 8'(sdram_host_pkg::T_XSR_CYC - 1);
                    next_cur.pend  = 1'b0;
                end else if (cur.pend && cur.pop == sdram_host_pkg::OP_SELF_IN) begin
                    next_cur.pend = 1'b0;
                end
                next_cur.refi = 16'(sdram_host_pkg::T_REFI_CYC - 1);
            end
            sdram_host_pkg::ST_XSR: begin
                if (cur.cnt == 8'h00) begin
                    next_cur.state    = sdram_host_pkg::ST_IDLE;
                    next_cur.ref_pend = cur.ref_en;
                end
            end
            sdram_host_pkg::ST_PDWN: begin
                // Leave early when refresh falls due, no refresh runs here
                if (cur.ref_pend || (cur.pend && cur.pop == sdram_host_pkg::OP_PD_OUT)) begin
                    next_cur.cke   = 1'b1;
                    next_cur.state = sdram_host_pkg::ST_IDLE;
                    next_cur.pend  = cur.pend && cur.pop != sdram_host_pkg::OP_PD_OUT;
                end
            end
            default: next_cur.state = sdram_host_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State register, frozen while ce is low
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur        <= '0;
            cur.state  <= sdram_host_pkg::ST_IDLE;
            cur.ref_en <= sdram_host_pkg::CTRL_REF_EN_RST;
            cur.bl     <= sdram_host_pkg::CTRL_BL_RST;
            cur.refi   <= 16'(sdram_host_pkg::T_REFI_CYC - 1);
            cur.cke    <= 1'b1;
            cur.cmd    <= sdram_host_pkg::PIN_NOP;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // Outputs come straight from the state register
    assign prdata   = cur.prdata;
    assign pready   = cur.pready;
    assign pslverr  = cur.pslverr;
    assign sd_cke   = cur.cke;
    assign sd_cs_n  = cur.cmd[3];
    assign sd_ras_n = cur.cmd[2];
    assign sd_cas_n = cur.cmd[1];
    assign sd_we_n  = cur.cmd[0];
    assign sd_ba    = cur.ba;
    assign sd_addr  = cur.a;
    assign sd_dqm   = cur.dqm;

endmodule // sdram_host

// ===== sdram_host_properties.sv
// Checker on the SDRAM host ports: refresh spacing, mask lead, power modes.
// One clock domain; bound into every sdram_host instance.
module sdram_host_props (
    // Clock, reset and SDRAM pins
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sd_cke,
    input wire logic sd_cs_n,
    input wire logic sd_ras_n,
    input wire logic sd_cas_n,
    input wire logic sd_we_n,
    input wire logic sd_dqm
);
    localparam int LIM = sdram_host_pkg::T_REFI_CYC * 3;
    logic [3:0]  cmd;
    logic        in_self;
    logic [15:0] gap;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
    // Self refresh flag; gap stays low while cke is low, power-down is policed elsewhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_self <= 1'b0;
            gap <= 16'h0;
        end else begin
            in_self <= !sd_cke && (in_self || cmd == sdram_host_pkg::PIN_REF);
            gap <= (cmd == sdram_host_pkg::PIN_REF || !sd_cke) ? 16'h0 : gap + 16'h1;
        end
    end
    sequence two_nops;
        (cmd == sdram_host_pkg::PIN_NOP) [*2];
    endsequence
    sequence mask_lead;
        sd_dqm [*2] ##[1:2] (cmd == sdram_host_pkg::PIN_WRITE);
    endsequence
    a_rfc_nops: assert property (cmd == sdram_host_pkg::PIN_REF && sd_cke |=> two_nops)
        else $error("command inside refresh time");
    a_pre_ref: assert property (cmd == sdram_host_pkg::PIN_PRE |=> cmd != 4'h1)
        else $error("refresh too soon after precharge");
    a_dqm_lead: assert property ($rose(sd_dqm) |-> mask_lead)
        else $error("mask lead wrong");
    a_cke_drop: assert property ($fell(sd_cke) |-> cmd == 4'h1 || cmd == 4'h7)
        else $error("bad command as cke falls");
    a_cke_quiet: assert property (!sd_cke && !$past(sd_cke) |-> cmd == 4'h7)
        else $error("command while cke low");
    a_wake_nop: assert property ($rose(sd_cke) |-> cmd == 4'h7)
        else $error("no nop as cke rises");
    a_xsr_nops: assert property ($rose(sd_cke) && in_self |-> two_nops)
        else $error("self refresh exit too short");
    a_ref_gap: assert property (gap < LIM)
        else $error("refresh overdue");
endmodule // sdram_host_props
bind sdram_host sdram_host_props sdram_host_props_i (.pclk(pclk), .presetn(presetn),
    .sd_cke(sd_cke), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
    .sd_we_n(sd_we_n), .sd_dqm(sd_dqm));

// ===== sdram_dev_model.sv
// Behavioural SDRAM: bank state, refresh count and a count of misuse.
// Pins sampled on clk rises; full_page mirrors the programmed burst length.
module sdram_dev_model (
    // Clock, bench reset and pins
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cke,
    input  wire logic [3:0]  cmd,
    input  wire logic [1:0]  ba,
    input  wire logic [11:0] addr,
    input  wire logic        full_page,
    // Observed state
    output logic      [3:0]  open_bank,
    output logic      [15:0] refs,
    output logic      [7:0]  bad
);
    logic cke_q;
    // A low cke stops the next internal edge, so its commands are lost
    always @(posedge clk) begin
        cke_q <= cke;
        if (!rst_n) begin
            {open_bank, refs, bad} <= '0;
        end else if (cke_q) begin
            case (cmd)
                4'h3: open_bank[ba] <= 1'b1;
                4'h2: open_bank <= addr[10] ? 4'h0 : open_bank & ~(4'h1 << ba);
                4'h5, 4'h4: begin
                    bad <= bad + 8'(!open_bank[ba]);
                    if (addr[10] && !full_page) open_bank[ba] <= 1'b0;
                end
                4'h1: begin
                    bad <= bad + 8'(open_bank != 4'h0);
                    refs <= refs + 16'h1;
                end
                default: ;
            endcase
        end
    end
endmodule // sdram_dev_model

// ===== sdram_host_tb.sv
// Bench: APB tasks drive the SDRAM host, the device model watches the pins.
// One 20 MHz clock; ce is held high throughout.
module sdram_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, full_page;
    logic        sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dqm;
    logic [1:0]  sd_ba;
    logic [3:0]  open_bank;
    logic [7:0]  paddr, bad;
    logic [11:0] sd_addr;
    logic [15:0] refs, r;
    logic [31:0] pwdata, prdata, q;
    int          err_count = 0;
    int          n_checks = 0;
    sdram_host sdram_host_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
        .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_ba(sd_ba),
        .sd_addr(sd_addr), .sd_dqm(sd_dqm));
    sdram_dev_model sdram_dev_model_i (.clk(pclk), .rst_n(presetn), .cke(sd_cke),
        .cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}), .ba(sd_ba), .addr(sd_addr),
        .full_page(full_page), .open_bank(open_bank), .refs(refs), .bad(bad));
    // Clock
    always #25 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; release is followed by an edge so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // No limit of its own: a slave that never answers is caught by the watchdog
        do @(posedge pclk); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // Post an operation, then poll until it is no longer pending
    task automatic issue(input logic [3:0] op, input logic [1:0] b, input logic a10);
        int n;
        n = 0;
        apb(1'b1, 8'h4, {25'h0, a10, b, op});
        do begin
            apb(1'b0, 8'h8, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 40);
        chk(32'(n < 40), 32'h1);
    endtask
    task automatic banks(input logic [3:0] x);
        apb(1'b0, 8'h8, 32'h0);
        chk(32'(q[5:2]), 32'(x));
        chk(32'(open_bank), 32'(x));
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Reset values, an unmapped access, then bank states with refresh off
    task automatic t_banks();
        apb(1'b0, 8'h0, 32'h0);
        chk(q, 32'h5);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, 8'h0, 32'h4);
        issue(4'h1, 0, 0);
        issue(4'h1, 2, 0);
        banks(4'h5);
        issue(4'h4, 0, 0);
        banks(4'h4);
        issue(4'h1, 1, 0);
        issue(4'h4, 3, 1);
        banks(4'h0);
        issue(4'h1, 3, 0);
        issue(4'h2, 3, 0);
        banks(4'h8);
        issue(4'h2, 3, 1);
        issue(4'h3, 0, 0);
        banks(4'h0);
    endtask
    // Full page read: suspended, resumed, then cut by a write to another bank
    task automatic t_cut();
        full_page <= 1'b1;
        apb(1'b1, 8'h0, 32'he);
        issue(4'h1, 0, 0);
        issue(4'h1, 1, 0);
        issue(4'h2, 0, 1);
        issue(4'ha, 0, 0);
        chk({q[12], sd_cke}, 32'h2);
        issue(4'hb, 0, 0);
        chk({q[12], sd_cke}, 32'h1);
        issue(4'h3, 1, 0);
        banks(4'h3);
        issue(4'h4, 0, 1);
        full_page <= 1'b0;
        apb(1'b1, 8'h0, 32'h5);
    endtask
    // Refresh with a bank open, self refresh, active power-down
    task automatic t_power();
        issue(4'h1, 2, 0);
        r = refs;
        while (refs === r) @(posedge pclk);
        banks(4'h0);
        issue(4'h6, 0, 0);
        chk(32'(sd_cke), 32'h0);
        issue(4'h7, 0, 0);
        chk(32'(sd_cke), 32'h1);
        apb(1'b0, 8'hc, 32'h0);
        chk(q, {16'h0, r + 16'h3});
        issue(4'h1, 1, 0);
        issue(4'h8, 0, 0);
        chk(32'(sd_cke), 32'h0);
        issue(4'h9, 0, 0);
        chk(32'(sd_cke), 32'h1);
        banks(4'h2);
    endtask
    // Main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, full_page, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_banks();
        t_cut();
        t_power();
        chk(32'(bad), 32'h0);
        stop_test();
    end
    // Watchdog, well past the expected run
    initial begin
        #2000000;
        err_count++;
        stop_test();
    end
endmodule // sdram_host_tb
